// ===== include/lap_regs.vh
`ifndef LAP_REGS_VH
`define LAP_REGS_VH
// register byte addresses (all printed offsets are multiples of four? no: indices kept, byte = 4 * index)
`define LAP_IDX_PULLUP 16'hffac
`define LAP_IDX_DIR 16'hffb0
`define LAP_IDX_LATCH 16'hffb2
`define LAP_ADDR_PULLUP 18'h3feb0
`define LAP_ADDR_DIR 18'h3fec0
`define LAP_ADDR_LATCH 18'h3fec8
// own register: mode and standby status view
`define LAP_ADDR_STATUS 18'h3fed0
// reset and forced values
`define LAP_RST_REG 8'h00
`define LAP_DIR_ALL_OUT 8'hff
`define LAP_WO_READ 8'hff
// mode encodings on the mode input
`define LAP_MODE_EXP_NOROM 2'h1
`define LAP_MODE_EXP_ROM 2'h2
`define LAP_MODE_SINGLE 2'h3
`endif

// ===== logic/lap_pin_cell.v
`timescale 1ns/100ps
`default_nettype none
// one pin's output-select and pull-up gating, combinational
module lap_pin_cell (
    input wire [1:0] mode,
    input wire hw_standby,
    input wire sw_standby,
    input wire dir_bit,
    input wire latch_bit,
    input wire addr_bit,
    input wire pullup_bit,
    output reg out_val,
    output reg out_en,
    output reg pullup_on
);
`include "lap_regs.vh"
    // pick what drives the pin for the current mode
    always @* begin
        out_val = 1'b0;
        out_en = 1'b0;
        pullup_on = 1'b0;
        if (hw_standby) begin
            // high impedance, pull-up off
            out_en = 1'b0;
        end else begin
            case (mode)
                `LAP_MODE_EXP_NOROM: begin
                    out_en = 1'b1;
                    out_val = sw_standby ? 1'b0 : addr_bit;
                    pullup_on = 1'b0;
                end
                `LAP_MODE_EXP_ROM: begin
                    out_en = dir_bit;
                    out_val = sw_standby ? 1'b0 : addr_bit;
                    pullup_on = pullup_bit & ~dir_bit;
                end
                default: begin
                    out_en = dir_bit;
                    out_val = latch_bit;
                    pullup_on = pullup_bit & ~dir_bit;
                end
            endcase
        end
    end
endmodule // lap_pin_cell
`default_nettype wire

// ===== logic/lap_read_mux.v
`timescale 1ns/100ps
`default_nettype none
// read data selection for the apb slave
module lap_read_mux (
    input wire [17:0] addr,
    input wire [7:0] pullup_reg,
    input wire [7:0] dir,
    input wire [7:0] latch,
    input wire [7:0] pins_in,
    input wire [1:0] mode,
    input wire sw_standby,
    output reg [31:0] rdata,
    output reg hit
);
`include "lap_regs.vh"
    always @* begin
        rdata = 32'h0;
        hit = 1'b1;
        case (addr)
            `LAP_ADDR_PULLUP: rdata = {24'h0, pullup_reg};
            `LAP_ADDR_DIR: rdata = {24'h0, `LAP_WO_READ};
            // outputs read the latch, inputs the pin
            `LAP_ADDR_LATCH: rdata = {24'h0, (latch & dir) | (pins_in & ~dir)};
            `LAP_ADDR_STATUS: rdata = {29'h0, sw_standby, mode};
            default: hit = 1'b0;
        endcase
    end
endmodule // lap_read_mux
`default_nettype wire

// ===== logic/lap_port.v
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module lap_port #(
    parameter WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [1:0] mode,
    input wire hw_standby,
    input wire sw_standby,
    input wire [WIDTH-1:0] addr_low,
    input wire [WIDTH-1:0] port_pins_seven_to_zero_in,
    output reg [WIDTH-1:0] port_pins_seven_to_zero_out,
    output reg [WIDTH-1:0] port_pins_seven_to_zero_oe,
    output reg [WIDTH-1:0] pullup_active
);
`include "lap_regs.vh"
    ////////////////////////////////////////////////////////////////
    // state
    reg [WIDTH-1:0] dir_ff; // direction, write only
    reg [WIDTH-1:0] latch_ff; // output latch
    reg [WIDTH-1:0] pullup_ff; // pull-up enables
    reg rst_seen_ff; // low for the first edge after reset release
    wire no_rom = (mode == `LAP_MODE_EXP_NOROM);
    // access phase of a write; single-cycle, always ready
    wire wr_go = psel & penable & pwrite;
    wire [31:0] rd_val;
    wire rd_hit;
    wire [WIDTH-1:0] nxt_out;
    wire [WIDTH-1:0] nxt_oe;
    wire [WIDTH-1:0] nxt_pu;
    ////////////////////////////////////////////////////////////////
    // write decode, shared by all three registers
    function lap_wr_hit;
        input go;
        input [17:0] a;
        input [17:0] target;
        begin
            // full address compare: aliases would corrupt neighbours
            lap_wr_hit = go & (a == target);
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    // registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= `LAP_RST_REG;
            latch_ff <= `LAP_RST_REG;
            pullup_ff <= `LAP_RST_REG;
            rst_seen_ff <= 1'b0;
        end else begin
            rst_seen_ff <= 1'b1;
            if (hw_standby) begin
                // clear data and pull-ups; direction too unless no-ROM
                latch_ff <= `LAP_RST_REG;
                pullup_ff <= `LAP_RST_REG;
                dir_ff <= no_rom ? `LAP_DIR_ALL_OUT : `LAP_RST_REG;
            end else begin
                // software standby simply keeps everything
                if (no_rom) begin
                    // every edge in no-ROM mode forces ones; direction writes are ignored
                    dir_ff <= `LAP_DIR_ALL_OUT;
                end else if (lap_wr_hit(wr_go, paddr, `LAP_ADDR_DIR)) begin
                    dir_ff <= pwdata[WIDTH-1:0];
                end
                if (lap_wr_hit(wr_go, paddr, `LAP_ADDR_LATCH)) begin
                    latch_ff <= pwdata[WIDTH-1:0];
                end
                // pull-up enables are stored as written; gating is per pin
                if (lap_wr_hit(wr_go, paddr, `LAP_ADDR_PULLUP)) begin
                    pullup_ff <= pwdata[WIDTH-1:0];
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // per-pin output cells
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
            lap_pin_cell u_cell (
                .mode(mode),
                .hw_standby(hw_standby),
                .sw_standby(sw_standby),
                .dir_bit(dir_ff[gi]),
                .latch_bit(latch_ff[gi]),
                .addr_bit(addr_low[gi]),
                .pullup_bit(pullup_ff[gi]),
                .out_val(nxt_out[gi]),
                .out_en(nxt_oe[gi]),
                .pullup_on(nxt_pu[gi])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////
    // registered pin drive; one cycle behind the controls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pins_seven_to_zero_out <= {WIDTH{1'b0}};
            port_pins_seven_to_zero_oe <= {WIDTH{1'b0}};
            pullup_active <= {WIDTH{1'b0}};
        end else begin
            port_pins_seven_to_zero_out <= nxt_out;
            port_pins_seven_to_zero_oe <= nxt_oe;
            pullup_active <= nxt_pu;
        end
    end
    ////////////////////////////////////////////////////////////////
    // apb read data; unmapped gives slverr
    lap_read_mux u_rd (
        .addr(paddr),
        .pullup_reg(pullup_ff),
        .dir(dir_ff),
        .latch(latch_ff),
        .pins_in(port_pins_seven_to_zero_in),
        .mode(mode),
        .sw_standby(sw_standby),
        .rdata(rd_val),
        .hit(rd_hit)
    );
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // ready answers in the setup cycle's next edge: zero wait
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_hit;
            prdata <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0;
        end
    end
endmodule // lap_port
`default_nettype wire

// ===== tb/lap_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "lap_regs.vh"
module lap_port_monitor (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_standby, sw_standby,
    input wire logic [1:0] mode,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [7:0] addr_low, port_pins_seven_to_zero_oe, port_pins_seven_to_zero_out, pullup_active
);
    // pin outputs are registered: each lags its cause by one edge
    wire [7:0] oe = port_pins_seven_to_zero_oe;
    wire [7:0] po = port_pins_seven_to_zero_out;
    wire st = psel && !penable;
    wire m1 = mode == `LAP_MODE_EXP_NOROM && !hw_standby;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; st |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer");
    property p_err; st && paddr == 18'h00010 |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_dir; st && !pwrite && paddr == `LAP_ADDR_DIR |=> prdata == 32'hff; endproperty
    a_dir: assert property (p_dir) else $error("dir read");
    property p_m1; (m1 && !sw_standby) [*2] |=> oe == 8'hff && po == $past(addr_low); endproperty
    a_m1: assert property (p_m1) else $error("address out");
    property p_sw; (m1 && sw_standby) [*2] |=> oe == 8'hff && po == 8'h00; endproperty
    a_sw: assert property (p_sw) else $error("standby low");
    property p_pu1; mode == `LAP_MODE_EXP_NOROM || hw_standby |=> pullup_active == 8'h00; endproperty
    a_pu1: assert property (p_pu1) else $error("pullup on");
    property p_hw; hw_standby |=> oe == 8'h00; endproperty
    a_hw: assert property (p_hw) else $error("hw drive");
    property p_pu8; (pullup_active & oe) == 8'h00; endproperty
    a_pu8: assert property (p_pu8) else $error("pullup out");
    c_wr: cover property (st && pwrite);
    c_hw: cover property ($rose(hw_standby));
    c_sw: cover property (m1 && sw_standby);
endmodule // lap_port_monitor
bind lap_port lap_port_monitor u_mon (.*);
`default_nettype wire

// ===== tb/lap_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
// far side: a wire carries the port's drive, else the outside level
module lap_ext_model (
    input wire logic [7:0] oe, drv, ext_val,
    output logic [7:0] pins
);
    assign pins = (oe & drv) | (~oe & ext_val);
endmodule // lap_ext_model
`default_nettype wire

// ===== tb/lap_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "lap_regs.vh"
module lap_port_tb;
    logic pclk, presetn, psel, penable, pwrite, hw_standby, sw_standby, pready, pslverr, se;
    logic [1:0] mode;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] addr_low, pins, out, oe, pu, ext_val;
    int err_total = 0, checks = 0;
    lap_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mode, .hw_standby, .sw_standby, .addr_low, .port_pins_seven_to_zero_in(pins),
        .port_pins_seven_to_zero_out(out), .port_pins_seven_to_zero_oe(oe), .pullup_active(pu));
    lap_ext_model u_ext (.oe, .drv(out), .ext_val, .pins);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got %h want %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up;
        end
    endtask
    // pins settle one edge after their cause; m masks undriven bits
    task chp(input logic [7:0] m, eo, ev, ep);
        repeat (3) @(posedge pclk);
        chk(oe, eo);
        chk(out & m, ev);
        chk(pu, ep);
    endtask
    task rst(input logic [1:0] m);
        {presetn, mode} <= {1'b0, m};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task t_gpio;
        chp(8'h00, 8'h00, 8'h00, 8'h00);
        apb(0, `LAP_ADDR_PULLUP, 0); chk(rd, 32'h0);
        apb(0, `LAP_ADDR_DIR, 0); chk(rd, 32'hff);
        apb(0, 18'h00010, 0); chk(se, 1'b1);
        apb(1, `LAP_ADDR_DIR, 8'hf0); apb(1, `LAP_ADDR_LATCH, 8'ha5); apb(1, `LAP_ADDR_PULLUP, 8'hff);
        chp(8'hf0, 8'hf0, 8'ha0, 8'h0f);
        apb(0, `LAP_ADDR_PULLUP, 0); chk(rd, 32'hff);
        chk(se, 1'b0);
        apb(0, `LAP_ADDR_LATCH, 0); chk(rd, 32'hac);
        sw_standby <= 1'b1; chp(8'hf0, 8'hf0, 8'ha0, 8'h0f);
        sw_standby <= 1'b0; $display("done gpio");
    endtask
    task t_rom;
        apb(1, `LAP_ADDR_DIR, 8'h0f); apb(1, `LAP_ADDR_PULLUP, 8'hff);
        chp(8'h0f, 8'h0f, 8'h06, 8'hf0);
        sw_standby <= 1'b1; chp(8'h0f, 8'h0f, 8'h00, 8'hf0);
        sw_standby <= 1'b0; apb(1, `LAP_ADDR_LATCH, 8'hff);
        hw_standby <= 1'b1; chp(8'h00, 8'h00, 8'h00, 8'h00);
        apb(1, `LAP_ADDR_PULLUP, 8'hff); hw_standby <= 1'b0;
        chp(8'h00, 8'h00, 8'h00, 8'h00);
        apb(0, `LAP_ADDR_PULLUP, 0); chk(rd, 32'h0);
        apb(1, `LAP_ADDR_DIR, 8'hff); apb(0, `LAP_ADDR_LATCH, 0); chk(rd, 32'h0);
        $display("done rom");
    endtask
    task t_m1;
        chp(8'hff, 8'hff, 8'h96, 8'h00);
        apb(1, `LAP_ADDR_DIR, 8'h00); apb(1, `LAP_ADDR_PULLUP, 8'hff);
        chp(8'hff, 8'hff, 8'h96, 8'h00);
        apb(0, `LAP_ADDR_STATUS, 0); chk(rd, 32'h1);
        sw_standby <= 1'b1; chp(8'hff, 8'hff, 8'h00, 8'h00);
        sw_standby <= 1'b0; hw_standby <= 1'b1; chp(8'h00, 8'h00, 8'h00, 8'h00);
        hw_standby <= 1'b0; chp(8'hff, 8'hff, 8'h96, 8'h00);
        $display("done m1");
    endtask
    initial begin
        {psel, penable, pwrite, hw_standby, sw_standby, paddr, pwdata} = '0;
        {presetn, mode, addr_low, ext_val} = {1'b0, 2'h3, 8'h96, 8'h3c};
        rst(2'h3); t_gpio;
        rst(2'h2); t_rom;
        rst(2'h1); t_m1;
        wrap_up;
    end
endmodule // lap_port_tb
`default_nettype wire
